//--- spt_serial_port.sv
// module: serial port with synchronous shift mode and 10-bit asynchronous mode, APB slave
// Summary of operation
// - buffer writes load transmit data; buffer reads return received byte.
// - asynchronous transmitter and receiver run independently, full duplex.
// - sync mode moves data on rxd pin, port always drives shift clock.
// - sync frames are eight bits, least significant first.
// - sync shift rate is clock/12 with option bit 0, clock/4 with 1.
// - sync buffer write starts shifting until all eight bits are out.
// - fast sync: data one clock before clock falls, clock low two.
// - slow sync: data three clocks before clock falls, clock low six.
// - sync transmit done flag sets right after the last bit period.
// - sync receive starts only with receive enable set, done flag clear.
// - sync receive samples rxd at each shift clock rise, eight bits.
// - sync receive done flag sets after last rise; blocks until cleared.
// - async frame: start 0, eight data bits lsb first, stop 1.
// - async received stop bit goes into the ninth received bit.
// - async bit rate is timer overflow rate divided by 16 or 32.
// - async transmit bits launch on successive divide-by-16 rollovers.
// - stop bit follows data; transmit done sets at tenth rollover.
// - async receive: 16x sampling, falling edge restart, 2-of-3 vote.
// - start bit voted high aborts and returns to edge hunting.
// - frame loads only if done flag clear and option 0 or stop 1.
//
// Register access over APB and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module spt_serial_port (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] prdata;
    logic [7:0] tx_data;
    logic [7:0] rx_buf;
    logic [1:0] mode;
    logic mode_opt;
    logic ren;
    logic rb8;
    logic ti;
    logic ri;
    logic baud_dbl;
    logic [15:0] reload;
    spt_pkg::spt_tx_state_t tx_st;
    logic tx_pend;
    logic [8:0] tx_shift;
    logic [3:0] tx_bits;
    logic [3:0] tx_div16;
    logic [3:0] m0_phase;
    spt_pkg::spt_pins_t pins;
    spt_pkg::spt_rx_state_t rx_st;
    logic [7:0] rx_shift;
    logic [3:0] rx_bits;
    logic [3:0] rx_div16;
    logic [1:0] rx_votes;
    logic rx_prev;
    logic [1:0] rxd_sync;
  } spt_state_t;

  spt_state_t q, d;
  spt_pkg::spt_apb_req_t req;
  logic t1_tick;
  logic tick16;
  logic rxd_s;
  logic access;
  logic mapped;
  logic vote;
  logic [3:0] m0_last;
  logic [3:0] m0_fall;
  logic [3:0] m0_rise;
  logic [3:0] ph_next;

  assign req = '{paddr: paddr, psel: psel, penable: penable, pwrite: pwrite, pwdata: pwdata};
  assign rxd_s = q.rxd_sync[1];

  // ----------------------------------------------------------------
  // baud generation
  // ----------------------------------------------------------------
  // reload register stands in for the timer: overflow every reload+1 clocks
  spt_tick_div u_timer_ovf (
    .pclk(pclk),
    .presetn(presetn),
    .en(1'b1),
    .last(q.reload),
    .tick(t1_tick)
  );

  // 16x sample tick: overflow rate, or half of it without doubling
  spt_tick_div u_baud16 (
    .pclk(pclk),
    .presetn(presetn),
    .en(t1_tick),
    .last({15'h0000, ~q.baud_dbl}),
    .tick(tick16)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  always_comb begin
    mapped = (req.paddr == spt_pkg::ADDR_SERIAL_BUFFER) || (req.paddr == spt_pkg::ADDR_SERIAL_CONTROL) ||
             (req.paddr == spt_pkg::ADDR_BAUD_CONTROL);
    access = req.psel && req.penable;
  end

  // shift-clock shape for the selected sync rate
  always_comb begin
    if (q.mode_opt) begin
      m0_last = spt_pkg::M0_FAST_LAST;
      m0_fall = spt_pkg::M0_FAST_FALL;
      m0_rise = spt_pkg::M0_FAST_RISE;
    end else begin
      m0_last = spt_pkg::M0_SLOW_LAST;
      m0_fall = spt_pkg::M0_SLOW_FALL;
      m0_rise = spt_pkg::M0_SLOW_RISE;
    end
    ph_next = (q.m0_phase == m0_last) ? 4'h0 : q.m0_phase + 4'h1;
    vote = (q.rx_votes[0] & q.rx_votes[1]) | (q.rx_votes[0] & rxd_s) | (q.rx_votes[1] & rxd_s);
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.rxd_sync = {q.rxd_sync[0], rxd_in};

    // read data is captured in the setup cycle so prdata leaves a flop
    if (req.psel && !req.penable && !req.pwrite) begin
      d.prdata = 32'h0000_0000;
      case (req.paddr)
        spt_pkg::ADDR_SERIAL_BUFFER: begin
          d.prdata[7:0] = q.rx_buf;
        end
        spt_pkg::ADDR_SERIAL_CONTROL: begin
          d.prdata[spt_pkg::CTRL_MODE_SELECT_HIGH] = q.mode[1];
          d.prdata[spt_pkg::CTRL_MODE_SELECT_LOW] = q.mode[0];
          d.prdata[spt_pkg::CTRL_MODE_OPTION_BIT] = q.mode_opt;
          d.prdata[spt_pkg::CTRL_RECEIVE_ENABLE] = q.ren;
          d.prdata[spt_pkg::CTRL_NINTH_RECEIVED_BIT] = q.rb8;
          d.prdata[spt_pkg::CTRL_TRANSMIT_DONE_FLAG] = q.ti;
          d.prdata[spt_pkg::CTRL_RECEIVE_DONE_FLAG] = q.ri;
        end
        spt_pkg::ADDR_BAUD_CONTROL: begin
          d.prdata[spt_pkg::BAUD_DOUBLING_BIT] = q.baud_dbl;
          d.prdata[spt_pkg::BAUD_RELOAD_LSB +: 16] = q.reload;
        end
        default: begin
          d.prdata = 32'h0000_0000;
        end
      endcase
    end

    // register writes first, so hardware flag sets below win over a clear
    if (access && req.pwrite && mapped) begin
      case (req.paddr)
        spt_pkg::ADDR_SERIAL_BUFFER: begin
          // a write during a frame is dropped; the shifter is never disturbed
          if (q.tx_st == spt_pkg::TX_IDLE && !q.tx_pend) begin
            d.tx_data = req.pwdata[7:0];
            d.tx_pend = 1'b1;
          end
        end
        spt_pkg::ADDR_SERIAL_CONTROL: begin
          d.mode = {req.pwdata[spt_pkg::CTRL_MODE_SELECT_HIGH], req.pwdata[spt_pkg::CTRL_MODE_SELECT_LOW]};
          d.mode_opt = req.pwdata[spt_pkg::CTRL_MODE_OPTION_BIT];
          d.ren = req.pwdata[spt_pkg::CTRL_RECEIVE_ENABLE];
          d.rb8 = req.pwdata[spt_pkg::CTRL_NINTH_RECEIVED_BIT];
          d.ti = req.pwdata[spt_pkg::CTRL_TRANSMIT_DONE_FLAG];
          d.ri = req.pwdata[spt_pkg::CTRL_RECEIVE_DONE_FLAG];
        end
        spt_pkg::ADDR_BAUD_CONTROL: begin
          d.baud_dbl = req.pwdata[spt_pkg::BAUD_DOUBLING_BIT];
          d.reload = req.pwdata[spt_pkg::BAUD_RELOAD_LSB +: 16];
        end
        default: begin
          d.tx_pend = q.tx_pend;
        end
      endcase
    end

    // shared sync-mode bit timer; only one sync direction runs at a time
    if (q.tx_st == spt_pkg::TX_SYNC || q.rx_st == spt_pkg::RX_SYNC) begin
      d.m0_phase = ph_next;
      if (ph_next == m0_fall) begin
        d.pins.txd_out = 1'b0;
      end
      if (ph_next == m0_rise) begin
        d.pins.txd_out = 1'b1;
      end
    end

    // ----------------------------------------------------------------
    // transmitter
    // ----------------------------------------------------------------
    if (tick16) begin
      d.tx_div16 = q.tx_div16 + 4'h1;
    end
    case (q.tx_st)
      spt_pkg::TX_IDLE: begin
        if (q.tx_pend && q.mode == spt_pkg::MODE_SYNC && q.rx_st == spt_pkg::RX_IDLE) begin
          d.tx_st = spt_pkg::TX_SYNC;
          d.tx_pend = 1'b0;
          d.tx_shift = {1'b1, q.tx_data};
          d.tx_bits = 4'h0;
          d.m0_phase = 4'h0;
          d.pins.rxd_out = q.tx_data[0];
          d.pins.rxd_oe = 1'b1;
          d.pins.txd_out = 1'b1;
        end else if (q.tx_pend && q.mode == spt_pkg::MODE_ASYNC10 && tick16 && q.tx_div16 == spt_pkg::DIV16_LAST) begin
          d.tx_st = spt_pkg::TX_ASYNC;
          d.tx_pend = 1'b0;
          d.tx_shift = {1'b1, q.tx_data};
          d.tx_bits = 4'h0;
          d.pins.txd_out = 1'b0;
        end
      end
      spt_pkg::TX_SYNC: begin
        if (q.m0_phase == m0_last) begin
          if (q.tx_bits == spt_pkg::LAST_DATA_BIT) begin
            d.tx_st = spt_pkg::TX_IDLE;
            d.ti = 1'b1;
            d.pins.rxd_oe = 1'b0;
            d.pins.rxd_out = 1'b1;
          end else begin
            // next bit appears at phase 0, fall and rise are counted from it
            d.tx_bits = q.tx_bits + 4'h1;
            d.tx_shift = {1'b1, q.tx_shift[8:1]};
            d.pins.rxd_out = q.tx_shift[1];
          end
        end
      end
      spt_pkg::TX_ASYNC: begin
        if (tick16 && q.tx_div16 == spt_pkg::DIV16_LAST) begin
          d.pins.txd_out = q.tx_shift[0];
          d.tx_shift = {1'b1, q.tx_shift[8:1]};
          d.tx_bits = q.tx_bits + 4'h1;
          if (q.tx_bits == spt_pkg::STOP_BIT_INDEX) begin
            d.tx_st = spt_pkg::TX_IDLE;
            d.ti = 1'b1;
          end
        end
      end
      default: begin
        d.tx_st = spt_pkg::TX_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    case (q.rx_st)
      spt_pkg::RX_IDLE: begin
        if (q.mode == spt_pkg::MODE_SYNC && q.ren && !q.ri && q.tx_st == spt_pkg::TX_IDLE && !q.tx_pend) begin
          d.rx_st = spt_pkg::RX_SYNC;
          d.rx_bits = 4'h0;
          d.m0_phase = 4'h0;
          d.pins.rxd_oe = 1'b0;
          d.pins.txd_out = 1'b1;
        end else if (tick16) begin
          d.rx_prev = rxd_s;
          if (q.mode == spt_pkg::MODE_ASYNC10 && q.ren && q.rx_prev && !rxd_s) begin
            d.rx_st = spt_pkg::RX_ASYNC;
            d.rx_div16 = 4'h0;
            d.rx_bits = 4'h0;
          end
        end
      end
      spt_pkg::RX_SYNC: begin
        // taken one cycle after the rise: the two-flop delay puts the pin sample
        // inside the low phase, after the partner's change at the fall
        if (q.m0_phase == m0_rise) begin
          d.rx_shift = {rxd_s, q.rx_shift[7:1]};
          d.rx_bits = q.rx_bits + 4'h1;
          if (q.rx_bits == spt_pkg::LAST_DATA_BIT) begin
            d.rx_buf = {rxd_s, q.rx_shift[7:1]};
            d.ri = 1'b1;
            d.rx_st = spt_pkg::RX_IDLE;
          end
        end
      end
      spt_pkg::RX_ASYNC: begin
        if (tick16) begin
          d.rx_div16 = q.rx_div16 + 4'h1;
          if (q.rx_div16 >= spt_pkg::VOTE_FIRST && q.rx_div16 < spt_pkg::VOTE_LAST) begin
            d.rx_votes = {q.rx_votes[0], rxd_s};
          end
          if (q.rx_div16 == spt_pkg::VOTE_LAST) begin
            d.rx_bits = q.rx_bits + 4'h1;
            if (q.rx_bits == 4'h0) begin
              if (vote) begin
                d.rx_st = spt_pkg::RX_IDLE;
                d.rx_prev = rxd_s;
              end
            end else if (q.rx_bits == spt_pkg::RX_STOP_INDEX) begin
              // mid stop bit: decide, then hunt for the next edge
              if (!q.ri && (!q.mode_opt || vote)) begin
                d.rx_buf = q.rx_shift;
                d.rb8 = vote;
                d.ri = 1'b1;
              end
              d.rx_st = spt_pkg::RX_IDLE;
              d.rx_prev = rxd_s;
            end else begin
              d.rx_shift = {vote, q.rx_shift[7:1]};
            end
          end
        end
        // switching mode away aborts the frame
        if (q.mode != spt_pkg::MODE_ASYNC10) begin
          d.rx_st = spt_pkg::RX_IDLE;
        end
      end
      default: begin
        d.rx_st = spt_pkg::RX_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.reload <= spt_pkg::RELOAD_RESET;
      q.tx_st <= spt_pkg::TX_IDLE;
      q.rx_st <= spt_pkg::RX_IDLE;
      q.pins <= '{txd_out: 1'b1, rxd_out: 1'b1, rxd_oe: 1'b0};
      q.rx_prev <= 1'b1;
      q.rxd_sync <= 2'h3;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = q.prdata;
  assign pready = access;
  assign pslverr = access && !mapped;
  assign txd_out = q.pins.txd_out;
  assign rxd_out = q.pins.rxd_out;
  assign rxd_oe = q.pins.rxd_oe;

endmodule // spt_serial_port

//--- spt_pkg.sv
// package: register map, field layout, timing counts and state types of the serial port
package spt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_BUFFER = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_CONTROL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_BAUD_CONTROL = 8'h08;

  // ----------------------------------------------------------------
  // serial_control_register fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_SELECT_HIGH = 7;
  localparam int CTRL_MODE_SELECT_LOW = 6;
  localparam int CTRL_MODE_OPTION_BIT = 5;
  localparam int CTRL_RECEIVE_ENABLE = 4;
  localparam int CTRL_NINTH_RECEIVED_BIT = 2;
  localparam int CTRL_TRANSMIT_DONE_FLAG = 1;
  localparam int CTRL_RECEIVE_DONE_FLAG = 0;
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_ASYNC10 = 2'h1;

  // ----------------------------------------------------------------
  // baud control fields
  // ----------------------------------------------------------------
  localparam int BAUD_DOUBLING_BIT = 0;
  localparam int BAUD_RELOAD_LSB = 16;
  localparam logic [15:0] RELOAD_RESET = 16'h0001;

  // ----------------------------------------------------------------
  // timing: sync phases in pclk cycles, async counts in 16x ticks, bit indices
  // ----------------------------------------------------------------
  localparam logic [3:0] M0_SLOW_LAST = 4'hb;
  localparam logic [3:0] M0_SLOW_FALL = 4'h3;
  localparam logic [3:0] M0_SLOW_RISE = 4'h9;
  localparam logic [3:0] M0_FAST_LAST = 4'h3;
  localparam logic [3:0] M0_FAST_FALL = 4'h1;
  localparam logic [3:0] M0_FAST_RISE = 4'h3;
  localparam logic [3:0] VOTE_FIRST = 4'h7;
  localparam logic [3:0] VOTE_LAST = 4'h9;
  localparam logic [3:0] DIV16_LAST = 4'hf;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] STOP_BIT_INDEX = 4'h8;
  localparam logic [3:0] RX_STOP_INDEX = 4'h9;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SYNC = 3'b010,
    TX_ASYNC = 3'b100
  } spt_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_SYNC = 3'b010,
    RX_ASYNC = 3'b100
  } spt_rx_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } spt_apb_req_t;

  typedef struct packed {
    logic txd_out;
    logic rxd_out;
    logic rxd_oe;
  } spt_pins_t;

endpackage

//--- spt_tick_div.sv
// module: programmable enable-pulse divider
`timescale 1ns/1ps
module spt_tick_div (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // count enable and terminal count
  input wire logic en,
  input wire logic [15:0] last,
  // one-cycle pulse every last+1 enables
  output logic tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } spt_div_state_t;

  spt_div_state_t q, d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (en) begin
      if (q.cnt >= last) begin
        d.cnt = 16'h0000;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule // spt_tick_div

//--- spt_serial_port_props.sv
// checker: port-level properties of the serial port
`timescale 1ns/1ps
module spt_serial_port_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [spt_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic rxd_out,
  input wire logic rxd_oe,
  input wire logic txd_out
);
  // ----------------
  // control shadow
  // ----------------
  logic [7:0] ctl_q;
  logic m0;
  logic fast;
  logic mapped;
  logic wr_buf;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= 8'h00;
    end else if (psel && penable && pwrite && paddr == spt_pkg::ADDR_SERIAL_CONTROL) begin
      ctl_q <= pwdata[7:0];
    end
  end
  assign m0 = ctl_q[7:6] == spt_pkg::MODE_SYNC;
  assign fast = ctl_q[spt_pkg::CTRL_MODE_OPTION_BIT];
  assign mapped = paddr inside {spt_pkg::ADDR_SERIAL_BUFFER, spt_pkg::ADDR_SERIAL_CONTROL, spt_pkg::ADDR_BAUD_CONTROL};
  assign wr_buf = psel && penable && pwrite && paddr == spt_pkg::ADDR_SERIAL_BUFFER;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------
  // properties
  // ----------------
  chk_apb_answer: assert property (psel && penable |-> pready && pslverr == !mapped)
    else $error("apb answer or error flag wrong");
  chk_oe_sync_only: assert property (rxd_oe |-> m0)
    else $error("data pin driven outside sync mode");
  chk_write_starts: assert property (wr_buf && m0 && !rxd_oe && !ctl_q[4] |-> ##2 rxd_oe)
    else $error("buffer write did not start shifting");
  chk_fast_low: assert property ($fell(txd_out) && m0 && fast |-> ##1 !txd_out ##1 txd_out)
    else $error("fast shift clock low time wrong");
  chk_slow_low: assert property ($fell(txd_out) && m0 && !fast |-> ##1 !txd_out [*5] ##1 txd_out)
    else $error("slow shift clock low time wrong");
  chk_data_lead: assert property (rxd_oe && $fell(txd_out) |-> $stable(rxd_out) && (fast || $past(rxd_out, 3) == rxd_out))
    else $error("data not set up before clock fall");
  chk_fast_rate: assert property (rxd_oe && fast && $fell(txd_out) |-> ##4 ($fell(txd_out) || !rxd_oe))
    else $error("fast shift period wrong");
  chk_slow_rate: assert property (rxd_oe && !fast && $fell(txd_out) |-> ##12 ($fell(txd_out) || !rxd_oe))
    else $error("slow shift period wrong");
  chk_frame_end: assert property ($fell(rxd_oe) |-> txd_out && rxd_out)
    else $error("pins not idle after frame");
  chk_async_start: assert property ($fell(txd_out) && ctl_q[7:6] == spt_pkg::MODE_ASYNC10 |-> !txd_out [*8])
    else $error("start bit too short");
  cover property (wr_buf && m0 && fast);
  cover property ($fell(rxd_oe));
  cover property ($fell(txd_out) && !m0);
endmodule // spt_serial_port_props
bind spt_serial_port spt_serial_port_props u_spt_serial_port_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));

//--- spt_partner.sv
// partner: external shift register and asynchronous link peer
`timescale 1ns/1ps
module spt_partner (
  // port pins
  input wire logic txd_out,
  input wire logic rxd_out,
  input wire logic rxd_oe,
  output logic rxd_in,
  // bench control
  input wire logic async_mode,
  input wire logic [7:0] sync_byte,
  input wire logic sync_load
);
  logic drv = 1'b1;
  logic [7:0] sh;
  logic [7:0] ash;
  logic [7:0] rx_q[$];
  logic stop_seen;
  int nfall;
  int nrise;
  // line has a pull-up; the port wins while it drives
  assign rxd_in = rxd_oe ? rxd_out : drv;
  always @(posedge sync_load) begin
    nfall = 0;
    drv <= sync_byte[0];
  end
  always @(negedge txd_out) begin
    if (!async_mode && !rxd_oe) begin
      nfall = nfall + 1;
      if (nfall > 1 && nfall <= 8) drv <= sync_byte[nfall-1];
    end
  end
  always @(posedge rxd_oe) nrise = 0;
  always @(posedge txd_out) begin
    if (!async_mode && !rxd_oe && nfall == 8) drv <= 1'b1;
    if (rxd_oe) begin
      sh = {rxd_in, sh[7:1]};
      nrise = nrise + 1;
      if (nrise == 8) rx_q.push_back(sh);
    end
  end
  // mid-bit sampling of what the port sends
  always @(negedge txd_out) begin
    if (async_mode) begin
      #80;
      if (txd_out == 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          #160;
          ash = {txd_out, ash[7:1]};
        end
        #160;
        stop_seen = txd_out;
        rx_q.push_back(ash);
      end
    end
  end
  task automatic send(input logic [7:0] b, input logic stop);
    drv = 1'b0;
    #160;
    for (int i = 0; i < 8; i++) begin
      drv = b[i];
      #160;
    end
    drv = stop;
    #160;
    drv = 1'b1;
  endtask
  task automatic glitch();
    drv = 1'b0;
    #30;
    drv = 1'b1;
    #200;
  endtask
endmodule // spt_partner

//--- spt_serial_port_tb_top.sv
// testbench: random and corner traffic through the serial port
`timescale 1ns/1ps
module spt_serial_port_tb_top;
  localparam logic [7:0] BF = spt_pkg::ADDR_SERIAL_BUFFER;
  localparam logic [7:0] CT = spt_pkg::ADDR_SERIAL_CONTROL;
  localparam logic [7:0] BD = spt_pkg::ADDR_BAUD_CONTROL;
  localparam logic [1:0] AS = spt_pkg::MODE_ASYNC10;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rxd_in;
  logic rxd_out;
  logic rxd_oe;
  logic txd_out;
  logic async_mode;
  logic [7:0] sync_byte;
  logic sync_load;
  logic [31:0] rd;
  logic err;
  logic [7:0] b;
  logic [7:0] b2;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  spt_serial_port u_spt_serial_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
  spt_partner u_spt_partner (.txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .rxd_in(rxd_in),
    .async_mode(async_mode), .sync_byte(sync_byte), .sync_load(sync_load));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // hang guard, well above the expected few thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic opt, input logic ren, input logic [2:0] fl);
    return {24'h0, m, opt, ren, 1'b0, fl};
  endfunction
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(a, 1'b0, 32'h0);
    check(s, e, rd);
  endtask
  task automatic wait_flags(input logic [31:0] m);
    int n;
    n = 0;
    do begin
      apb(CT, 1'b0, 32'h0);
      n++;
    end while ((rd & m) !== m && n < 400);
    check("flag wait", m, rd & m);
  endtask
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    async_mode = 1'b0;
    sync_byte = 8'h00;
    sync_load = 1'b0;
    presetn = 1'b0;
    b = 8'($urandom(32'hfff8));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(CT, 32'h0, "control reset");
    rdc(BD, {spt_pkg::RELOAD_RESET, 16'h0}, "baud reset");
    apb(8'h0c, 1'b1, 32'hffff_ffff);
    rdc(8'h0c, 32'h0, "unmapped read");
    check("unmapped error", 32'h1, {31'h0, err});
    for (int o = 0; o < 2; o++) begin
      b = 8'($urandom());
      b2 = 8'($urandom());
      apb(CT, 1'b1, ctl(spt_pkg::MODE_SYNC, o[0], 1'b0, 3'h0));
      apb(BF, 1'b1, {24'h0, b});
      wait_flags(32'h2);
      check("sync tx flags", ctl(spt_pkg::MODE_SYNC, o[0], 1'b0, 3'h2), rd);
      check("sync tx byte", {24'h0, b}, {24'h0, u_spt_partner.rx_q.pop_front()});
      sync_byte <= b2;
      @(posedge pclk);
      sync_load <= 1'b1;
      @(posedge pclk);
      sync_load <= 1'b0;
      apb(CT, 1'b1, ctl(spt_pkg::MODE_SYNC, o[0], 1'b1, 3'h0));
      wait_flags(32'h1);
      rdc(BF, {24'h0, b2}, "sync rx byte");
      repeat (60) @(posedge pclk);
      check("reception held", 32'd8, 32'(u_spt_partner.nfall));
      apb(CT, 1'b1, 32'h0);
    end
    async_mode <= 1'b1;
    for (int c = 0; c < 2; c++) begin
      b = 8'($urandom());
      b2 = 8'($urandom());
      apb(BD, 1'b1, c == 0 ? 32'h0001_0001 : 32'h0);
      apb(CT, 1'b1, ctl(AS, 1'b0, 1'b1, 3'h0));
      fork
        apb(BF, 1'b1, {24'h0, b});
        u_spt_partner.send(b2, 1'b1);
      join
      wait_flags(32'h3);
      check("async flags", ctl(AS, 1'b0, 1'b1, 3'h7), rd);
      repeat (40) @(posedge pclk);
      check("async tx byte", {24'h0, b}, {24'h0, u_spt_partner.rx_q.pop_front()});
      check("async stop bit", 32'h1, {31'h0, u_spt_partner.stop_seen});
      rdc(BF, {24'h0, b2}, "async rx byte");
      u_spt_partner.send(~b2, 1'b1);
      rdc(BF, {24'h0, b2}, "frame while flag up");
      apb(CT, 1'b1, ctl(AS, 1'b1, 1'b1, 3'h0));
      u_spt_partner.send(b ^ 8'h5a, 1'b0);
      repeat (40) @(posedge pclk);
      rdc(CT, ctl(AS, 1'b1, 1'b1, 3'h0), "bad stop dropped");
      u_spt_partner.glitch();
      u_spt_partner.send(b, 1'b1);
      wait_flags(32'h1);
      rdc(BF, {24'h0, b}, "after false start");
      apb(CT, 1'b1, 32'h0);
    end
    test_done();
  end
endmodule // spt_serial_port_tb_top
